// ===== verilog/pan_adv_regs.sv
// per-port auto-negotiation advertisement registers
`timescale 1ns/1ps
`default_nettype none
`include "pan_consts.svh"
module pan_adv_regs
   import pan_pkg::*;
#(
   parameter int NUM_PORTS = 2
) (
   input  wire logic                 clk_i,
   input  wire logic                 sys_rst_i,
   input  wire logic [NUM_PORTS-1:0] manual_pause_pin_default_i,
   input  wire logic [NUM_PORTS-1:0] full_duplex_pause_pin_default_i,
   input  wire logic [NUM_PORTS-1:0] autoneg_pin_default_i,
   input  wire logic [NUM_PORTS-1:0] speed_pin_default_i,
   input  wire logic [NUM_PORTS-1:0] duplex_pin_default_i,
   input  wire logic                 reload_i,
   input  wire logic                 mgmt_wr_i,
   input  wire logic [1:0]           mgmt_port_i,
   input  wire logic [4:0]           mgmt_index_i,
   input  wire logic [15:0]          mgmt_wdata_i,
   output logic      [15:0]          mgmt_rdata_o,
   output logic                      load_done_o
);
   // every port shows this image until the first load
   localparam logic [15:0] RESET_IMAGE = `PAN_ADV_RESET;

   pan_state_t           state;

   // strap levels, latched once per chip reset release
   logic [NUM_PORTS-1:0] st_man;
   logic [NUM_PORTS-1:0] st_fdfc;
   logic [NUM_PORTS-1:0] st_an;
   logic [NUM_PORTS-1:0] st_spd;
   logic [NUM_PORTS-1:0] st_dup;

   // register image per port, bits 15, 14 and 9 already zero; bit 12 holds what was written
   logic [15:0]          adv [NUM_PORTS];

   logic                 capture_now;
   logic                 load_now;
   logic                 hit;
   logic [15:0]          next_rdata;

   assign hit = (mgmt_index_i == `PAN_ADV_INDEX);

   assign capture_now = (state == PAN_IDLE);

   // load one cycle after capture so the defaults see the latched straps
   assign load_now = (state == PAN_CAPTURE);

   // idle catches the straps, capture loads the defaults, run serves software
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state <= PAN_IDLE;
      end else begin
         case (state)
            PAN_IDLE: begin
               state <= PAN_CAPTURE;
            end
            PAN_CAPTURE: begin
               state <= PAN_RUN;
            end
            PAN_RUN: begin
               // a reload goes straight to the load state and keeps the old straps
               if (reload_i) begin
                  state <= PAN_CAPTURE;
               end
            end
            default: begin
               state <= PAN_IDLE;
            end
         endcase
      end
   end

   // a pin change after release only counts at the next chip reset
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_man  <= '0;
         st_fdfc <= '0;
      end else if (capture_now) begin
         st_man  <= manual_pause_pin_default_i;
         st_fdfc <= full_duplex_pause_pin_default_i;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_an  <= '0;
         st_spd <= '0;
         st_dup <= '0;
      end else if (capture_now) begin
         st_an  <= autoneg_pin_default_i;
         st_spd <= speed_pin_default_i;
         st_dup <= duplex_pin_default_i;
      end
   end

   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         logic [15:0] dflt;
         logic        wr_en;

         logic        rfault;
         logic        rsvd12;
         logic [1:0]  pause;
         logic [1:0]  ability_100;
         logic [1:0]  ability_10;
         logic [4:0]  sel;

         // the loader owns the load cycle; a write there is lost
         assign wr_en = mgmt_wr_i && hit && (mgmt_port_i == 2'(p));

         // loader image built from the latched straps
         always_comb begin
            dflt = RESET_IMAGE;
            dflt[`PAN_BIT_SYM]  = 1'b0;
            dflt[`PAN_BIT_ASYM] = 1'b0;
            if (!st_man[p]) begin
               dflt[`PAN_BIT_SYM]  = 1'b1;
               dflt[`PAN_BIT_ASYM] = st_fdfc[p];
            end
            dflt[`PAN_BIT_TFD] = st_an[p] | (~st_spd[p] & st_dup[p]);
            dflt[`PAN_BIT_THD] = st_an[p] | ~st_spd[p];
         end

         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               rfault <= RESET_IMAGE[`PAN_BIT_RFAULT];
            end else if (load_now) begin
               rfault <= dflt[`PAN_BIT_RFAULT];
            end else if (wr_en) begin
               rfault <= mgmt_wdata_i[`PAN_BIT_RFAULT];
            end
         end

         // stored as written; keeping it zero is up to software
         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               rsvd12 <= RESET_IMAGE[`PAN_BIT_RSVD12];
            end else if (load_now) begin
               rsvd12 <= dflt[`PAN_BIT_RSVD12];
            end else if (wr_en) begin
               rsvd12 <= mgmt_wdata_i[`PAN_BIT_RSVD12];
            end
         end

         // index 1 is asymmetric pause, index 0 symmetric pause
         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               pause <= RESET_IMAGE[`PAN_BIT_ASYM:`PAN_BIT_SYM];
            end else if (load_now) begin
               pause <= dflt[`PAN_BIT_ASYM:`PAN_BIT_SYM];
            end else if (wr_en) begin
               pause <= mgmt_wdata_i[`PAN_BIT_ASYM:`PAN_BIT_SYM];
            end
         end

         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               ability_100 <= RESET_IMAGE[`PAN_BIT_TXFD:`PAN_BIT_TXHD];
            end else if (load_now) begin
               ability_100 <= dflt[`PAN_BIT_TXFD:`PAN_BIT_TXHD];
            end else if (wr_en) begin
               ability_100 <= mgmt_wdata_i[`PAN_BIT_TXFD:`PAN_BIT_TXHD];
            end
         end

         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               ability_10 <= RESET_IMAGE[`PAN_BIT_TFD:`PAN_BIT_THD];
            end else if (load_now) begin
               ability_10 <= dflt[`PAN_BIT_TFD:`PAN_BIT_THD];
            end else if (wr_en) begin
               ability_10 <= mgmt_wdata_i[`PAN_BIT_TFD:`PAN_BIT_THD];
            end
         end

         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               sel <= RESET_IMAGE[`PAN_SEL_MSB:0];
            end else if (load_now) begin
               sel <= dflt[`PAN_SEL_MSB:0];
            end else if (wr_en) begin
               sel <= mgmt_wdata_i[`PAN_SEL_MSB:0];
            end
         end

         // bits 15, 14 and 9 have no storage and read as zero
         assign adv[p] = {2'b00, rfault, rsvd12, pause, 1'b0,
                          ability_100, ability_10, sel};
      end
   endgenerate

   // the port select only reaches four ports; absent ones never match
   always_comb begin
      next_rdata = 16'h0000;
      for (int i = 0; i < NUM_PORTS; i++) begin
         if (hit && (mgmt_port_i == 2'(i))) begin
            next_rdata = adv[i];
         end
      end
   end

   // unmapped index or absent port reads as zero
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mgmt_rdata_o <= 16'h0000;
      end else begin
         mgmt_rdata_o <= next_rdata;
      end
   end

   // low through the whole load so software knows when to write
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         load_done_o <= 1'b0;
      end else begin
         load_done_o <= (state == PAN_RUN) && !reload_i;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/pan_consts.svh
// constants for the per-port advertisement register bank
// What this block does
// - Each port: 16-bit read-write register, index 4.
// - Loader rewrites register after reset or reload.
// - Bit 13 advertises remote fault, resets zero.
// - Bit 11 asymmetric pause, bit 10 symmetric.
// - Bits 8,7 advertise 100BASE-X, reset one.
// - Bits 6,5 advertise 10BASE-T, strap defaults.
// - Bits 4:0 selector field, reset 00001.
// - Manual strap low: symmetric one, asymmetric strap.
// - Manual strap high: both pause bits zero.
// - Straps captured when chip reset releases.
// - 10T full default: autoneg OR (~speed AND duplex).
// - 10T half default: autoneg OR ~speed.
`ifndef PAN_CONSTS_SVH
`define PAN_CONSTS_SVH
`define PAN_ADV_INDEX     5'h04
`define PAN_BIT_RFAULT    13
`define PAN_BIT_RSVD12    12
`define PAN_BIT_ASYM      11
`define PAN_BIT_SYM       10
`define PAN_BIT_TXFD      8
`define PAN_BIT_TXHD      7
`define PAN_BIT_TFD       6
`define PAN_BIT_THD       5
`define PAN_SEL_MSB       4
`define PAN_SEL_RESET     5'h01
`define PAN_ADV_RESET     16'h0181
`define PAN_WMASK         16'h3DFF
`endif

// ===== verilog/pan_pkg.sv
// types shared by the advertisement register bank
package pan_pkg;
   typedef enum logic [1:0] {PAN_IDLE, PAN_CAPTURE, PAN_RUN} pan_state_t;
endpackage

// ===== testbench/pan_adv_regs_assertions.sv
// checker for the advertisement register bank
`timescale 1ns/1ps
`default_nettype none
module pan_adv_regs_chk #(parameter int NUM_PORTS = 2) (
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic        reload_i,
   input wire logic        mgmt_wr_i,
   input wire logic [1:0]  mgmt_port_i,
   input wire logic [4:0]  mgmt_index_i,
   input wire logic [15:0] mgmt_wdata_i,
   input wire logic [15:0] mgmt_rdata_o,
   input wire logic        load_done_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   wire logic hit = mgmt_index_i == 5'h04 && mgmt_port_i < NUM_PORTS;
   chk_rsvd_zero: assert property (mgmt_rdata_o[15:14] == 2'h0 && !mgmt_rdata_o[9])
      else $error("reserved bit set");
   chk_unmapped_zero: assert property (mgmt_index_i != 5'h04 |=> mgmt_rdata_o == 16'h0)
      else $error("unmapped read not zero");
   chk_port_range: assert property (mgmt_port_i >= NUM_PORTS |=> mgmt_rdata_o == 16'h0)
      else $error("bad port read not zero");
   chk_reload_busy: assert property (reload_i |=> !load_done_o)
      else $error("reload not started");
   chk_reload_done: assert property (reload_i |-> ##[2:6] load_done_o)
      else $error("reload not finished");
   chk_write_back: assert property (mgmt_wr_i && hit && load_done_o && !reload_i ##1 hit
      && !mgmt_wr_i && !reload_i && $stable(mgmt_port_i)
      |=> mgmt_rdata_o == ($past(mgmt_wdata_i, 2) & 16'h3DFF))
      else $error("write not read back");
   chk_sel_default: assert property ($rose(load_done_o) && hit |=> mgmt_rdata_o[4:0] == 5'h01)
      else $error("selector default wrong");
   chk_fixed_default: assert property ($rose(load_done_o) && hit
      |=> mgmt_rdata_o[13:12] == 2'h0 && mgmt_rdata_o[8:7] == 2'h3)
      else $error("fixed default wrong");
   cover property (reload_i);
   cover property ($rose(load_done_o));
   cover property (mgmt_wr_i && hit);
endmodule
bind pan_adv_regs pan_adv_regs_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.clk_i, .sys_rst_i,
   .reload_i, .mgmt_wr_i, .mgmt_port_i, .mgmt_index_i, .mgmt_wdata_i, .mgmt_rdata_o, .load_done_o);
`default_nettype wire

// ===== testbench/pan_adv_regs_bench.sv
// self-checking bench for the advertisement register bank
`timescale 1ns/1ps
`default_nettype none
module pan_adv_regs_bench;
   logic        clk_i = 0, sys_rst_i = 1, reload_i = 0, mgmt_wr_i = 0, load_done_o;
   logic [1:0]  man = 0, fdfc = 0, an = 0, spd = 0, dup = 0, mgmt_port_i = 0;
   logic [4:0]  mgmt_index_i = 5'h04;
   logic [15:0] mgmt_wdata_i = 0, mgmt_rdata_o;
   int          error_cnt = 0, total_checks = 0;
   logic [15:0] keep0;
   always #2.5 clk_i = ~clk_i;
   pan_adv_regs #(.NUM_PORTS(2)) DUT (.clk_i, .sys_rst_i, .manual_pause_pin_default_i(man),
      .full_duplex_pause_pin_default_i(fdfc), .autoneg_pin_default_i(an),
      .speed_pin_default_i(spd), .duplex_pin_default_i(dup), .reload_i, .mgmt_wr_i,
      .mgmt_port_i, .mgmt_index_i, .mgmt_wdata_i, .mgmt_rdata_o, .load_done_o);
   function automatic logic [15:0] dflt(int p);
      return 16'h0181 | {4'h0, ~man[p] & fdfc[p], ~man[p], 3'h0,
         an[p] | (~spd[p] & dup[p]), an[p] | ~spd[p], 5'h00};
   endfunction
   task chk(input string n, input logic [15:0] s, e);
      total_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s exp %h got %h", n, e, s);
      end
   endtask
   task rd(input logic [1:0] p, input logic [4:0] x, input logic [15:0] e);
      @(posedge clk_i) {mgmt_port_i, mgmt_index_i} <= {p, x};
      @(posedge clk_i);
      @(negedge clk_i) chk("mgmt_rdata_o", mgmt_rdata_o, e);
   endtask
   task wr(input logic [1:0] p, input logic [15:0] d);
      @(posedge clk_i) {mgmt_wr_i, mgmt_port_i, mgmt_index_i, mgmt_wdata_i} <= {1'b1, p, 5'h04, d};
      @(posedge clk_i) mgmt_wr_i <= 0;
   endtask
   task wait_done;
      // bounded so a stuck loader shows up as failed reads, not a hang
      @(negedge clk_i);
      for (int k = 0; k < 20 && load_done_o !== 1'b1; k++) @(negedge clk_i);
   endtask
   task chip_reset;
      @(posedge clk_i) sys_rst_i <= 1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 0;
      wait_done();
   endtask
   task results;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #20000 error_cnt++;
      results();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 0;
      wait_done();
      chk("load_done_o", load_done_o, 16'h0001);
      rd(0, 5'h04, dflt(0));
      wr(1, 16'hEFFF);
      rd(1, 5'h04, 16'h2DFF);
      rd(1, 5'h05, 16'h0000);
      rd(3, 5'h04, 16'h0000);
      // straps only count at a chip reset, so each set gets one
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i) {an, spd, dup} <= {i[2], ~i[2], i[1], ~i[1], i[0], ~i[0]};
         {man, fdfc} <= {i[0], i[1], i[2], ~i[0]};
         chip_reset();
         rd(0, 5'h04, dflt(0));
         rd(1, 5'h04, dflt(1));
      end
      // a reload restores the latched defaults and ignores moved pins
      keep0 = dflt(0);
      wr(0, 16'h2C1E);
      rd(0, 5'h04, 16'h2C1E);
      @(posedge clk_i) {man, fdfc, an, spd, dup} <= ~{man, fdfc, an, spd, dup};
      reload_i <= 1;
      @(posedge clk_i) reload_i <= 0;
      @(negedge clk_i) chk("load_done_o", load_done_o, 16'h0000);
      wait_done();
      chk("load_done_o", load_done_o, 16'h0001);
      rd(0, 5'h04, keep0);
      results();
   end
endmodule
`default_nettype wire
